// *** core/odip_top.sv ***
// octal digital input packer: channels, input image and Wishbone registers
//
// Notes on behaviour
// - eight independent channels, each giving a status and a line-fault bit
// - input changes up to 50 Hz are followed without loss
// - image is sent to the com unit every 6.5 ms, only while the code is valid and the configuration matches
// - off delay, one per channel pair (1/5, 2/6, 3/7, 4/8), holds back one-to-zero changes
// - in word mode high byte of each word goes first, else ascending
// - byte 1: channels 5-8, status on even bits, fault on odd bits
// - byte 2: channels 1-4 in the same interleaved pattern
// - fault bit is 0 while line healthy, 1 while fault seen
// - code selects image size: 11/31 two bytes, 33 four, 37 eight
// - output bytes of codes 31/33/37 are ignored; code 11 has none
// - supervision detects break and short, enabled per channel
// - active inputs only when the com unit option is set
// - configuration mismatch with master blocks cyclic exchange
// - on delay, one per channel pair (1/5, 2/6, 3/7, 4/8), suppresses short zero-to-one pulses
// - negation reports the complement of the sensed input
// - on fault the error mode gives current, substitute or last value
`timescale 1ns/1ns
module odip_top
    import odip_pkg::*;
#(
    parameter int PERIOD_CLKS  = CYCLE_CLKS, // clocks per image period
    parameter int MS_TICK_CLKS = MS_CLKS     // clocks per delay tick
) (
    input  wire logic              CLK,        // 50 MHz clock
    input  wire logic              SYS_RST,    // async reset, active high
    input  wire logic [7:0]        FIELD_IN,   // sensed field levels
    input  wire logic [7:0]        LINE_ERR,   // front-end break/short flags
    input  wire logic [7:0]        ACTIVE_SEL, // channels wired as active inputs
    input  wire logic              WB_CYC_I,   // wishbone cycle
    input  wire logic              WB_STB_I,   // wishbone strobe
    input  wire logic              WB_WE_I,    // wishbone write enable
    input  wire logic [7:0]        WB_ADR_I,   // wishbone byte address
    input  wire logic [3:0]        WB_SEL_I,   // wishbone byte selects
    input  wire logic [31:0]       WB_DAT_I,   // wishbone write data
    output logic [31:0]            WB_DAT_O,   // wishbone read data
    output logic                   WB_ACK_O,   // wishbone acknowledge
    output logic                   WB_ERR_O,   // wishbone error, unmapped
    output logic [7:0]             TX_DATA,    // byte to com unit
    output logic                   TX_VALID,   // byte valid strobe
    output logic                   TX_FIRST,   // first byte of an image
    output logic                   TX_LAST,    // last byte of an image
    input  wire logic              TX_READY,   // com unit accepts byte
    input  wire logic [7:0]        RX_DATA,    // output byte from com unit
    input  wire logic              RX_VALID,   // output byte strobe
    output logic                   IRQ         // level interrupt
);
    // =========================================================
    // registers
    // =========================================================
    logic [31:0]    ctrl_reg;
    logic [7:0]     supv_reg;
    logic [7:0]     neg_reg;
    logic [7:0]     subst_reg;
    logic [15:0]    emode_reg;
    logic [63:0]    ondly_reg;
    logic [63:0]    offdly_reg;
    logic [2:0]     irq_st_reg;
    logic [2:0]     irq_msk_reg;
    logic           ack_reg;
    logic           err_reg;
    logic [31:0]    rdata_reg;
    logic [15:0]    image_reg;
    logic [7:0]     prev_fault_reg;
    logic [31:0]    tick_reg;
    logic [15:0]    ms_reg;
    logic [3:0]     idx_reg;
    odip_tx_state_t state_reg;

    odip_ch_out_t   ch_res [NUM_CH];
    logic [7:0]     ch_status;
    logic [7:0]     ch_fault;

    // =========================================================
    // bus decode
    // =========================================================
    wire        req      = WB_CYC_I & WB_STB_I & ~ack_reg & ~err_reg;
    wire        wr       = req & WB_WE_I;
    wire        rd       = req & ~WB_WE_I;
    wire        hit_ctrl = WB_ADR_I == ADDR_CTRL;
    wire        hit_supv = WB_ADR_I == ADDR_SUPV;
    wire        hit_neg  = WB_ADR_I == ADDR_NEG;
    wire        hit_sub  = WB_ADR_I == ADDR_SUBST;
    wire        hit_em   = WB_ADR_I == ADDR_EMODE;
    wire        hit_on   = WB_ADR_I == ADDR_ONDLY;
    wire        hit_off  = WB_ADR_I == ADDR_OFFDLY;
    wire        hit_img  = WB_ADR_I == ADDR_IMAGE;
    wire        hit_stat = WB_ADR_I == ADDR_STAT;
    wire        hit_ist  = WB_ADR_I == ADDR_IRQ_ST;
    wire        hit_msk  = WB_ADR_I == ADDR_IRQ_MSK;
    wire        hit_any  = hit_ctrl | hit_supv | hit_neg | hit_sub | hit_em | hit_on |
                           hit_off | hit_img | hit_stat | hit_ist | hit_msk;
    wire [31:0] bmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                            {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    // one delay word serves channels 1-4; channels 5-8 mirror the same bytes
    wire [31:0] wmerge_ctrl = (ctrl_reg & ~bmask) | (WB_DAT_I & bmask);

    wire [7:0]  code       = ctrl_reg[CTRL_CODE_LSB +: 8];
    wire        word_mode  = ctrl_reg[CTRL_WORD_BIT];
    wire        allow_act  = ctrl_reg[CTRL_ACTIVE_BIT];
    wire        cfg_match  = ctrl_reg[CTRL_MATCH_BIT];
    wire        code_ok    = code == CODE_STANDARD | code == CODE_TWO |
                             code == CODE_FOUR | code == CODE_EIGHT;
    // image size per code; unknown code sends nothing
    wire [3:0]  nbytes     = (code == CODE_EIGHT) ? NBYTES_EIGHT :
                             (code == CODE_FOUR)  ? NBYTES_FOUR  :
                             code_ok              ? NBYTES_TWO   : NBYTES_NONE;
    // cyclic exchange only while master and station configuration agree
    wire        run        = cfg_match & code_ok;

    // =========================================================
    // channels
    // =========================================================
    wire ms_tick = ms_reg == 16'(MS_TICK_CLKS - 1);

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            odip_ch_cfg_t cfg;
            assign cfg = '{supv_en: supv_reg[g], negate: neg_reg[g], subst_val: subst_reg[g],
                           emode: odip_emode_t'(emode_reg[2*g +: 2]),
                           on_dly_ms: ondly_reg[8*g +: 8], off_dly_ms: offdly_reg[8*g +: 8]};
            odip_channel u_ch (
                .clk          (CLK),
                .rst          (SYS_RST),
                .ms_tick      (ms_tick),
                .raw_in       (FIELD_IN[g]),
                .line_err     (LINE_ERR[g]),
                .allow_active (allow_act),
                .active_sel   (ACTIVE_SEL[g]),
                .cfg          (cfg),
                .res          (ch_res[g])
            );
            assign ch_status[g] = ch_res[g].status;
            assign ch_fault[g]  = ch_res[g].fault;
        end
    endgenerate

    // =========================================================
    // input image
    // =========================================================
    // byte 1 carries channels 5-8, byte 2 channels 1-4, status then fault
    wire [7:0] byte1 = {ch_fault[7], ch_status[7], ch_fault[6], ch_status[6],
                        ch_fault[5], ch_status[5], ch_fault[4], ch_status[4]};
    wire [7:0] byte2 = {ch_fault[3], ch_status[3], ch_fault[2], ch_status[2],
                        ch_fault[1], ch_status[1], ch_fault[0], ch_status[0]};

    // word mode swaps each byte pair so the high byte (byte 2) goes first
    wire [3:0] send_idx  = word_mode ? {idx_reg[3:1], ~idx_reg[0]} : idx_reg;
    wire [7:0] send_byte = (send_idx == 4'h0) ? image_reg[15:8] :
                           (send_idx == 4'h1) ? image_reg[7:0]  : 8'h00;
    wire       last_byte = idx_reg == nbytes - 4'h1;
    wire       period    = tick_reg == 32'(PERIOD_CLKS - 1);
    wire       new_fault = |(ch_fault & ~prev_fault_reg);

    // =========================================================
    // transmit state machine
    // =========================================================
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tick_reg  <= ZERO_WORD;
            ms_reg    <= 16'h0000;
            state_reg <= TX_IDLE;
            idx_reg   <= 4'h0;
            image_reg <= 16'h0000;
        end else begin
            tick_reg <= period ? ZERO_WORD : tick_reg + 32'h0000_0001;
            ms_reg   <= ms_tick ? 16'h0000 : ms_reg + 16'h0001;
            unique case (state_reg)
                TX_IDLE: begin
                    if (period && run && nbytes != NBYTES_NONE) begin
                        image_reg <= {byte1, byte2};
                        idx_reg   <= 4'h0;
                        state_reg <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (TX_READY) begin
                        idx_reg <= idx_reg + 4'h1;
                        if (last_byte) begin
                            state_reg <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign TX_VALID = state_reg == TX_SEND;
    assign TX_DATA  = send_byte;
    assign TX_FIRST = TX_VALID & (idx_reg == 4'h0);
    assign TX_LAST  = TX_VALID & last_byte;
    // output bytes from the com unit are accepted and discarded
    wire rx_unused = RX_VALID & |RX_DATA;

    // =========================================================
    // register access and interrupts
    // =========================================================
    wire [2:0] irq_ev = {~run, new_fault, TX_LAST & TX_READY};
    wire       rd_ist = rd & hit_ist;

    always_comb begin
        WB_DAT_O = rdata_reg;
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_reg       <= ZERO_WORD;
            supv_reg       <= 8'h00;
            neg_reg        <= 8'h00;
            subst_reg      <= 8'h00;
            emode_reg      <= 16'h0000;
            ondly_reg      <= 64'h0000_0000_0000_0000;
            offdly_reg     <= 64'h0000_0000_0000_0000;
            irq_st_reg     <= 3'b000;
            irq_msk_reg    <= 3'b000;
            ack_reg        <= 1'b0;
            err_reg        <= 1'b0;
            rdata_reg      <= ZERO_WORD;
            prev_fault_reg <= 8'h00;
        end else begin
            ack_reg        <= req & hit_any;
            err_reg        <= req & ~hit_any;
            prev_fault_reg <= ch_fault;
            // a new event wins over the clearing read
            irq_st_reg     <= (rd_ist ? 3'b000 : irq_st_reg) | irq_ev;
            if (wr && hit_ctrl) ctrl_reg <= wmerge_ctrl;
            if (wr && hit_supv && WB_SEL_I[0]) supv_reg <= WB_DAT_I[7:0];
            if (wr && hit_neg && WB_SEL_I[0]) neg_reg <= WB_DAT_I[7:0];
            if (wr && hit_sub && WB_SEL_I[0]) subst_reg <= WB_DAT_I[7:0];
            if (wr && hit_em) emode_reg <= WB_DAT_I[15:0];
            if (wr && hit_on) ondly_reg <= {WB_DAT_I, WB_DAT_I};
            if (wr && hit_off) offdly_reg <= {WB_DAT_I, WB_DAT_I};
            if (wr && hit_msk && WB_SEL_I[0]) irq_msk_reg <= WB_DAT_I[2:0];
            // writes and unmapped requests answer with zero data
            rdata_reg <= !req ? rdata_reg :
                         wr ? ZERO_WORD :
                         hit_ctrl ? ctrl_reg :
                         hit_supv ? {24'h00_0000, supv_reg} :
                         hit_neg  ? {24'h00_0000, neg_reg} :
                         hit_sub  ? {24'h00_0000, subst_reg} :
                         hit_em   ? {16'h0000, emode_reg} :
                         hit_on   ? ondly_reg[31:0] :
                         hit_off  ? offdly_reg[31:0] :
                         hit_img  ? {16'h0000, byte1, byte2} :
                         hit_stat ? {16'h0000, ch_fault, ch_status} :
                         hit_ist  ? {29'h0000_0000, irq_st_reg} :
                         hit_msk  ? {29'h0000_0000, irq_msk_reg} : ZERO_WORD;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_ERR_O = err_reg;
    assign IRQ      = |(irq_st_reg & irq_msk_reg);
endmodule : odip_top

// *** core/odip_pkg.sv ***
// package: constants, types and register map of the octal digital input packer
package odip_pkg;
    localparam int          NUM_CH          = 8;
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          CYCLE_US        = 6500;
    localparam int          CYCLE_CLKS      = (CLK_HZ / 1_000_000) * CYCLE_US;
    localparam int          MS_US           = 1000;
    localparam int          MS_CLKS         = (CLK_HZ / 1_000_000) * MS_US;
    localparam int          MAX_IN_HZ       = 50;
    localparam int          MAX_BYTES       = 8;
    // register word offsets (byte addresses)
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_SUPV       = 8'h04;
    localparam logic [7:0]  ADDR_NEG        = 8'h08;
    localparam logic [7:0]  ADDR_SUBST      = 8'h0c;
    localparam logic [7:0]  ADDR_EMODE      = 8'h10;
    localparam logic [7:0]  ADDR_ONDLY      = 8'h14;
    localparam logic [7:0]  ADDR_OFFDLY     = 8'h18;
    localparam logic [7:0]  ADDR_IMAGE      = 8'h1c;
    localparam logic [7:0]  ADDR_STAT       = 8'h20;
    localparam logic [7:0]  ADDR_IRQ_ST     = 8'h24;
    localparam logic [7:0]  ADDR_IRQ_MSK    = 8'h28;
    // control register fields
    localparam int          CTRL_CODE_LSB   = 0;
    localparam int          CTRL_WORD_BIT   = 8;
    localparam int          CTRL_ACTIVE_BIT = 9;
    localparam int          CTRL_MATCH_BIT  = 10;
    // layout selection codes
    localparam logic [7:0]  CODE_STANDARD   = 8'h11;
    localparam logic [7:0]  CODE_TWO        = 8'h31;
    localparam logic [7:0]  CODE_FOUR       = 8'h33;
    localparam logic [7:0]  CODE_EIGHT      = 8'h37;
    localparam logic [3:0]  NBYTES_TWO      = 4'h2;
    localparam logic [3:0]  NBYTES_FOUR     = 4'h4;
    localparam logic [3:0]  NBYTES_EIGHT    = 4'h8;
    localparam logic [3:0]  NBYTES_NONE     = 4'h0;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
    // interrupt status bits
    localparam int          IRQ_FRAME_BIT   = 0;
    localparam int          IRQ_FAULT_BIT   = 1;
    localparam int          IRQ_CFGERR_BIT  = 2;

    typedef enum logic [1:0] {
        EM_CURRENT    = 2'b00,
        EM_SUBSTITUTE = 2'b01,
        EM_LAST_VALID = 2'b10
    } odip_emode_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01
    } odip_tx_state_t;

    // one channel's configuration
    typedef struct packed {
        logic        supv_en;
        logic        negate;
        logic        subst_val;
        odip_emode_t emode;
        logic [7:0]  on_dly_ms;
        logic [7:0]  off_dly_ms;
    } odip_ch_cfg_t;

    // one channel's result
    typedef struct packed {
        logic status;
        logic fault;
    } odip_ch_out_t;
endpackage : odip_pkg

// *** core/odip_channel.sv ***
// one input channel: supervision, on/off delay, negation and error mode
`timescale 1ns/1ns
module odip_channel
    import odip_pkg::*;
(
    input  wire logic         clk,      // module clock
    input  wire logic         rst,      // async reset, active high
    input  wire logic         ms_tick,  // one-cycle pulse each millisecond
    input  wire logic         raw_in,   // sensed field level
    input  wire logic         line_err, // front end reports break or short
    input  wire logic         allow_active, // active inputs allowed
    input  wire logic         active_sel,   // channel wired as active input
    input  wire odip_ch_cfg_t cfg,      // channel configuration
    output odip_ch_out_t      res       // packed status and fault
);
    logic       filt_reg;
    logic       filt_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       last_reg;
    logic       fault_reg;

    // active wiring without the option is treated as a line error
    wire        active_bad = active_sel & ~allow_active;
    // active wiring only meaningful with supervision off
    wire        sup_on     = cfg.supv_en & ~active_sel;
    wire        fault      = (sup_on & line_err) | active_bad;
    wire        differs    = raw_in != filt_reg;
    wire [7:0]  dly        = raw_in ? cfg.on_dly_ms : cfg.off_dly_ms;
    wire        expire     = differs & (cnt_reg >= dly);
    wire        logical    = filt_reg ^ cfg.negate;

    // delays are counted on the ms tick; a zero delay follows in one cycle
    assign filt_next = expire ? raw_in : filt_reg;
    assign cnt_next  = !differs || expire ? 8'h00 :
                       (ms_tick && cnt_reg != 8'hff) ? cnt_reg + 8'h01 : cnt_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_reg  <= 1'b0;
            cnt_reg   <= 8'h00;
            last_reg  <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            filt_reg  <= filt_next;
            cnt_reg   <= cnt_next;
            fault_reg <= fault;
            if (!fault) begin
                last_reg <= logical;
            end
        end
    end

    // error mode chooses what stands for the status during a fault
    always_comb begin
        res.fault  = fault_reg;
        res.status = logical;
        if (fault_reg) begin
            unique case (cfg.emode)
                EM_SUBSTITUTE: res.status = cfg.subst_val;
                EM_LAST_VALID: res.status = last_reg;
                default:       res.status = logical;
            endcase
        end
    end
endmodule : odip_channel

// *** bench/odip_sva.sv ***
// checker: bus answer and image stream assertions for the input packer
`timescale 1ns/1ns
module odip_sva (
    input wire logic        CLK,      // module clock
    input wire logic        SYS_RST,  // async reset, active high
    input wire logic        WB_CYC_I, // bus cycle
    input wire logic        WB_STB_I, // bus strobe
    input wire logic [31:0] WB_DAT_O, // read data
    input wire logic        WB_ACK_O, // acknowledge
    input wire logic        WB_ERR_O, // error answer
    input wire logic [7:0]  TX_DATA,  // image byte
    input wire logic        TX_VALID, // byte valid
    input wire logic        TX_FIRST, // first byte
    input wire logic        TX_LAST,  // last byte
    input wire logic        TX_READY  // com unit ready
);
    logic [3:0] beat_reg;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O; endsequence
    sequence s_beat; TX_VALID && TX_READY; endsequence
    // =========================================
    // bytes accepted so far in the current image
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST)
            beat_reg <= 4'h0;
        else if (TX_VALID && TX_READY)
            beat_reg <= TX_LAST ? 4'h0 : beat_reg + 4'h1;
    end
    a_bus_answer: assert property (s_req |=> WB_ACK_O || WB_ERR_O)
        else $error("bus request not answered in the next cycle");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without a request");
    a_err_zero: assert property (WB_ERR_O |-> WB_DAT_O == 32'h0000_0000 && !WB_ACK_O)
        else $error("error answer with data or ack");
    a_byte_hold: assert property (
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
        else $error("stalled byte changed");
    a_first_mark: assert property ($rose(TX_VALID) |-> TX_FIRST && beat_reg == 4'h0)
        else $error("image does not start with first byte");
    a_image_len: assert property (
        s_beat ##0 TX_LAST |-> beat_reg == 4'h1 || beat_reg == 4'h3 || beat_reg == 4'h7)
        else $error("image length not 2, 4 or 8");
    a_frame_end: assert property (s_beat ##0 TX_LAST |=> !TX_VALID)
        else $error("valid after last byte");
    a_pad_zero: assert property (TX_VALID && beat_reg >= 4'h2 |-> TX_DATA == 8'h00)
        else $error("padding byte not zero");
endmodule : odip_sva

// *** bench/odip_com_model.sv ***
// com unit model: takes image bytes, stalling at random when asked to
`timescale 1ns/1ns
module odip_com_model #(
    parameter int STALL = 1 // 1 stalls at random, 0 always ready
) (
    input  wire logic       clk,      // module clock
    input  wire logic       rst,      // async reset
    input  wire logic [7:0] tx_data,  // image byte
    input  wire logic       tx_valid, // byte valid
    input  wire logic       tx_last,  // last byte
    output logic            tx_ready  // accept strobe
);
    logic [7:0]  got[$];
    int          frames;
    logic [31:0] s = 32'h1234_5677;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_ready <= 1'b0;
            frames   <= 0;
        end else begin
            s = s ^ (s << 13);
            s = s ^ (s >> 17);
            s = s ^ (s << 5);
            if (tx_valid && tx_ready) begin
                got.push_back(tx_data);
                if (tx_last)
                    frames <= frames + 1;
            end
            tx_ready <= (STALL == 0) || s[0];
        end
    end
endmodule : odip_com_model

// *** bench/odip_test.sv ***
// testbench: random field levels and settings, image frames checked
`timescale 1ns/1ns
module odip_test;
    import odip_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rxv = 1'b0;
    logic [7:0]  field_in = 8'h00, line_err = 8'h00, adr = 8'h00, rxd = 8'h00, act = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, q, rd, xs_state = 32'h0000_0041;
    logic [7:0]  tx_data, neg, supv, subst;
    logic        ack, err, tx_valid, tx_first, tx_last, tx_ready, irq, e;
    logic [7:0]  exp_q[$];
    int          n_fail = 0, total_checks = 0, cycles = 0;
    always #10 clk = ~clk;
    // short period and tick so that one run sees several images and delays
    odip_top #(.PERIOD_CLKS(2000), .MS_TICK_CLKS(50)) dut (.CLK(clk), .SYS_RST(sys_rst),
        .FIELD_IN(field_in), .LINE_ERR(line_err),
        .ACTIVE_SEL(act), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(q), .WB_ACK_O(ack), .WB_ERR_O(err),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_FIRST(tx_first), .TX_LAST(tx_last),
        .TX_READY(tx_ready), .RX_DATA(rxd), .RX_VALID(rxv), .IRQ(irq));
    odip_com_model #(.STALL(1)) com (.clk(clk), .rst(sys_rst), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
    function automatic logic [7:0] xs();
        xs_state = xs_state ^ (xs_state << 13);
        xs_state = xs_state ^ (xs_state >> 17);
        xs_state = xs_state ^ (xs_state << 5);
        return xs_state[7:0];
    endfunction : xs
    // =========================================
    // reference image: one nibble of channels, status even, fault odd
    // active wiring without the option counts as a fault
    function automatic logic [7:0] pk(input int base, input logic subm, input logic alw);
        logic [7:0] r;
        logic       flt;
        for (int k = 0; k < 4; k++) begin
            flt        = (act[base+k] & ~alw) | (line_err[base+k] & supv[base+k]);
            r[2*k]     = (flt && subm) ? subst[base+k] : field_in[base+k] ^ neg[base+k];
            r[2*k+1]   = flt;
        end
        return r;
    endfunction : pk
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        total_checks++;
        if (got !== want) begin
            n_fail++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, want);
        end
    endtask : chk
    // holds the request until ack or err is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (!(ack || err));
        rd = q;
        e  = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic frame(input int n, input int off);
        while (com.frames < n) @(posedge clk);
        chk(com.got.size(), off + exp_q.size(), "image length");
        foreach (exp_q[i]) chk({24'h0, com.got[off+i]}, {24'h0, exp_q[i]}, "image byte");
    endtask : frame
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // =========================================
    // output bytes keep changing, they must have no effect on the image
    always @(posedge clk) begin
        cycles++;
        rxd <= rxd + 8'h35;
        rxv <= ~rxv;
        if (cycles >= 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst  <= 1'b0;
        neg      = xs();
        supv     = xs();
        subst    = xs();
        field_in <= xs();
        line_err <= xs();
        wb(1'b1, ADDR_SUPV, {24'h0, supv});
        wb(1'b1, ADDR_NEG, {24'h0, neg});
        wb(1'b1, ADDR_SUBST, {24'h0, subst});
        wb(1'b1, ADDR_IRQ_MSK, 32'h0000_0001);
        wb(1'b1, ADDR_CTRL, 32'h0000_0411);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped data");
        exp_q = '{pk(4, 1'b0, 1'b0), pk(0, 1'b0, 1'b0)};
        frame(1, 0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0001, "frame interrupt");
        wb(1'b0, ADDR_IRQ_ST, 32'h0000_0000);
        chk(rd & 32'h0000_0001, 32'h0000_0001, "frame status bit");
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000, "interrupt cleared by read");
        // second image: active channels unsupervised, option off, substitute, word order
        neg      = 8'h00;
        supv     = xs();
        act      <= ~supv;
        field_in <= xs();
        line_err <= xs();
        wb(1'b1, ADDR_NEG, 32'h0000_0000);
        wb(1'b1, ADDR_SUPV, {24'h0, supv});
        wb(1'b1, ADDR_EMODE, 32'h0000_5555);
        wb(1'b1, ADDR_CTRL, 32'h0000_0537);
        exp_q = '{pk(0, 1'b1, 1'b0), pk(4, 1'b1, 1'b0),
                  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        frame(2, 2);
        // third image: active inputs allowed, four bytes in ascending order
        field_in <= xs();
        wb(1'b1, ADDR_CTRL, 32'h0000_0633);
        exp_q = '{pk(4, 1'b1, 1'b1), pk(0, 1'b1, 1'b1), 8'h00, 8'h00};
        frame(3, 10);
        // on and off delays of two ticks, no faults
        line_err <= 8'h00;
        field_in <= 8'h00;
        wb(1'b1, ADDR_ONDLY, 32'h0202_0202);
        wb(1'b1, ADDR_OFFDLY, 32'h0202_0202);
        field_in <= 8'hff;
        wb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk(rd & 32'h0000_00ff, 32'h0000_0000, "on delay holds zero");
        repeat (250) @(posedge clk);
        wb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk(rd & 32'h0000_00ff, 32'h0000_00ff, "on delay expired");
        field_in <= 8'h00;
        wb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk(rd & 32'h0000_00ff, 32'h0000_00ff, "off delay stretches");
        repeat (250) @(posedge clk);
        wb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk(rd & 32'h0000_00ff, 32'h0000_0000, "off delay expired");
        report_and_stop();
    end
endmodule : odip_test
bind odip_top odip_sva u_sva (.CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
    .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_FIRST(TX_FIRST), .TX_LAST(TX_LAST),
    .TX_READY(TX_READY));
